// file: hdl/efc_pkg.sv
// Constants and types shared by the calibration and memory command block
package efc_pkg;
	localparam logic [7:0] CMD_PAGE_READ = 8'h42;
	localparam logic [7:0] CMD_PAGE_WRITE = 8'h50;
	localparam logic [7:0] CMD_BULK_ERASE = 8'h4f;
	localparam logic [7:0] CMD_AUTO_FREQ = 8'h76;
	localparam logic [7:0] CMD_SAVE_NV = 8'h53;
	localparam logic [7:0] RSP_ACK = 8'h06;
	localparam logic [7:0] RSP_NAK = 8'h15;
	localparam logic [15:0] DELIM_KEY = 16'ha5a5;
	localparam logic [15:0] ERASED_WORD = 16'hffff;
	localparam int NUM_WORDS = 256;
	localparam int NUM_PAGES = 32;
	localparam int PAGE_WORDS = 8;
	localparam int PAGE_BYTES = 16;
	localparam logic [7:0] LAST_PAGE = 8'h1f;
	localparam logic [31:0] GAIN_MIN = 32'h000061a8;
	localparam logic [31:0] GAIN_MAX = 32'h0000ffff;
	localparam logic [15:0] FREQ_MIN_MHZ = 16'hafc8;
	localparam logic [15:0] FREQ_MAX_MHZ = 16'hfde8;
	localparam logic [15:0] FREQ_REF_RST = 16'hc350;
	localparam logic [15:0] GAIN_FACTORY = 16'h8000;
	localparam logic [15:0] DELIM_RST = 16'h0000;
	localparam logic [7:0] FREQ_MULT_CYCLES = 8'h20;
	localparam int DIV_CYCLES = 34;
	typedef enum logic [3:0] {
		ST_IDLE = 4'h0,
		ST_PAGE_NUM = 4'h1,
		ST_WDATA = 4'h2,
		ST_ERASE = 4'h3,
		ST_RD_ACK = 4'h4,
		ST_RD_DATA = 4'h5,
		ST_RD_SUM = 4'h6,
		ST_CAL_DIV = 4'h7,
		ST_RESP = 4'h8
	} efc_state_type;
endpackage : efc_pkg

// file: hdl/efc_divider.sv
// Sequential unsigned divider for the gain ratio
`timescale 1ns/100ps
module efc_divider (
	input wire logic clk_in,
	input wire logic sys_rst_in,
	input wire logic start_in,
	input wire logic [31:0] num_in,
	input wire logic [15:0] den_in,
	output logic done_out,
	output logic [31:0] quot_out
);
	import efc_pkg::*;
	typedef struct packed {
		logic [5:0] cnt;
		logic busy;
		logic done;
		logic [31:0] q;
		logic [16:0] rem;
	} efc_div_type;
	efc_div_type cur_ff, nxt_ff;
	logic [16:0] trial;
	always_comb begin
		nxt_ff = cur_ff;
		nxt_ff.done = 1'b0;
		trial = {cur_ff.rem[15:0], cur_ff.q[31]};
		if (start_in) begin
			nxt_ff.busy = 1'b1;
			nxt_ff.cnt = 6'h00;
			nxt_ff.q = num_in;
			nxt_ff.rem = 17'h00000;
		end else if (cur_ff.busy) begin
			nxt_ff.q = {cur_ff.q[30:0], 1'b0};
			if (trial >= {1'b0, den_in}) begin
				nxt_ff.rem = trial - {1'b0, den_in};
				nxt_ff.q[0] = 1'b1;
			end else begin
				nxt_ff.rem = trial;
			end
			nxt_ff.cnt = cur_ff.cnt + 6'h01;
			if (cur_ff.cnt == 6'h1f) begin
				nxt_ff.busy = 1'b0;
				nxt_ff.done = 1'b1;
			end
		end
	end
	always_ff @(posedge clk_in) begin
		if (sys_rst_in)
			cur_ff <= '0;
		else
			cur_ff <= nxt_ff;
	end
	assign done_out = cur_ff.done;
	assign quot_out = cur_ff.q;
endmodule : efc_divider

// file: hdl/efc_nvstore.sv
// Nonvolatile calibration store with factory fallback
`timescale 1ns/100ps
module efc_nvstore (
	input wire logic clk_in,
	input wire logic save_in,
	input wire logic [15:0] gain_in,
	input wire logic [15:0] delim_in,
	output logic [15:0] gain_out
);
	import efc_pkg::*;
	// Persistent cells are not cleared by the system reset
	typedef struct packed {
		logic user_valid;
		logic [15:0] gain;
	} efc_nv_type;
	efc_nv_type cur_ff, nxt_ff;
	always_comb begin
		nxt_ff = cur_ff;
		if (save_in) begin
			if (delim_in == DELIM_KEY) begin
				nxt_ff.user_valid = 1'b0;
			end else begin
				nxt_ff.user_valid = 1'b1;
				nxt_ff.gain = gain_in;
			end
		end
	end
	always_ff @(posedge clk_in) begin
		cur_ff <= nxt_ff;
	end
	// Factory gain stays in use until a user save
	assign gain_out = (cur_ff.user_valid === 1'b1) ? cur_ff.gain
		: GAIN_FACTORY;
endmodule : efc_nvstore

// file: hdl/efc_cmd.sv
// Command interpreter for frequency calibration and user memory pages
// Behaviour
// - The measured line frequency is kept as a 16-bit result.
// - A frequency outside 45 to 65 Hz is flagged invalid.
// - Auto calibration updates only the frequency gain by expected/measured.
// - The new gain must lie in 25000..65535 for ACK, else NAK.
// - A save after calibration stores the constants persistently.
// - Key 0xa5a5, a save and a reset restore factory calibration.
// - Factory values persist across resets until a new calibrated save.
// - The memory holds 256 readable and writable 16-bit words.
// - It has 32 pages of eight words and erased words read ffff.
// - Page read is 0x42 plus page, answered ACK, data and checksum.
// - Page write is 0x50, page, 16 data bytes, answered ACK.
// - Bulk erase is 0x4f alone, erases to all ones, answered ACK.
`timescale 1ns/100ps
module efc_cmd (
	input wire logic clk_in,
	input wire logic sys_rst_in,
	input wire logic rx_valid_in,
	input wire logic [7:0] rx_data_in,
	output logic rx_ready_out,
	output logic tx_valid_out,
	output logic [7:0] tx_data_out,
	input wire logic tx_ready_in,
	input wire logic freq_valid_in,
	input wire logic [15:0] freq_meas_in,
	input wire logic [15:0] freq_ref_in,
	input wire logic ref_load_in,
	input wire logic [15:0] delim_in,
	input wire logic delim_load_in,
	output logic [15:0] line_freq_out,
	output logic freq_ok_out,
	output logic [15:0] freq_gain_out
);
	import efc_pkg::*;
	typedef struct packed {
		efc_state_type st;
		logic [7:0] cmd;
		logic [7:0] page;
		logic [3:0] idx;
		logic [7:0] lo;
		logic [7:0] sum;
		logic [7:0] resp;
		logic [8:0] erase_ptr;
		logic [15:0] line_freq;
		logic freq_ok;
		logic [15:0] gain;
		logic [15:0] ref_f;
		logic [15:0] delim;
		logic [15:0] meas;
		logic div_go;
		logic save;
		logic loaded;
	} efc_top_type;
	efc_top_type cur_ff, nxt_ff;
	logic [15:0] mem_ff [NUM_WORDS];
	logic mem_we;
	logic [7:0] mem_waddr;
	logic [15:0] mem_wdata;
	logic div_done;
	logic [31:0] div_quot;
	logic [31:0] div_num;
	logic [15:0] nv_gain;
	logic [7:0] rd_byte;
	function automatic logic [7:0] word_addr(input logic [7:0] pg,
		input logic [3:0] i);
		word_addr = {pg[4:0], i[3:1]};
	endfunction : word_addr
	function automatic logic freq_in_band(input logic [15:0] f);
		freq_in_band = (f >= FREQ_MIN_MHZ) && (f <= FREQ_MAX_MHZ);
	endfunction : freq_in_band
	// Full 32-bit product so the gain ratio keeps every bit
	assign div_num = 32'(cur_ff.gain) * 32'(cur_ff.ref_f);
	efc_divider u_div (
		.clk_in(clk_in),
		.sys_rst_in(sys_rst_in),
		.start_in(cur_ff.div_go),
		.num_in(div_num),
		.den_in(cur_ff.meas),
		.done_out(div_done),
		.quot_out(div_quot)
	);
	efc_nvstore u_nv (
		.clk_in(clk_in),
		.save_in(cur_ff.save),
		.gain_in(cur_ff.gain),
		.delim_in(cur_ff.delim),
		.gain_out(nv_gain)
	);
	assign rd_byte = cur_ff.idx[0]
		? mem_ff[word_addr(cur_ff.page, cur_ff.idx)][7:0]
		: mem_ff[word_addr(cur_ff.page, cur_ff.idx)][15:8];
	always_comb begin
		nxt_ff = cur_ff;
		nxt_ff.div_go = 1'b0;
		nxt_ff.save = 1'b0;
		mem_we = 1'b0;
		mem_waddr = 8'h00;
		mem_wdata = ERASED_WORD;
		if (!cur_ff.loaded) begin
			nxt_ff.gain = nv_gain;
			nxt_ff.loaded = 1'b1;
		end
		if (freq_valid_in) begin
			nxt_ff.line_freq = freq_meas_in;
			nxt_ff.freq_ok = freq_in_band(freq_meas_in);
		end
		if (ref_load_in)
			nxt_ff.ref_f = freq_ref_in;
		if (delim_load_in)
			nxt_ff.delim = delim_in;
		unique case (cur_ff.st)
		ST_IDLE: begin
			if (rx_valid_in) begin
				nxt_ff.cmd = rx_data_in;
				nxt_ff.idx = 4'h0;
				nxt_ff.sum = 8'h00;
				if (rx_data_in == CMD_PAGE_READ ||
					rx_data_in == CMD_PAGE_WRITE) begin
					nxt_ff.st = ST_PAGE_NUM;
				end else if (rx_data_in == CMD_BULK_ERASE) begin
					nxt_ff.erase_ptr = 9'h000;
					nxt_ff.st = ST_ERASE;
				end else if (rx_data_in == CMD_AUTO_FREQ) begin
					// relies on host applying the reference
					if (cur_ff.freq_ok && cur_ff.line_freq != 16'h0000) begin
						nxt_ff.meas = cur_ff.line_freq;
						nxt_ff.div_go = 1'b1;
						nxt_ff.st = ST_CAL_DIV;
					end else begin
						nxt_ff.resp = RSP_NAK;
						nxt_ff.st = ST_RESP;
					end
				end else if (rx_data_in == CMD_SAVE_NV) begin
					nxt_ff.save = 1'b1;
					nxt_ff.resp = RSP_ACK;
					nxt_ff.st = ST_RESP;
				end else begin
					nxt_ff.resp = RSP_NAK;
					nxt_ff.st = ST_RESP;
				end
			end
		end
		ST_PAGE_NUM: begin
			if (rx_valid_in) begin
				nxt_ff.page = rx_data_in;
				if (cur_ff.cmd == CMD_PAGE_READ) begin
					if (rx_data_in > LAST_PAGE) begin
						nxt_ff.resp = RSP_NAK;
						nxt_ff.st = ST_RESP;
					end else begin
						nxt_ff.st = ST_RD_ACK;
					end
				end else begin
					nxt_ff.st = ST_WDATA;
				end
			end
		end
		ST_WDATA: begin
			if (rx_valid_in) begin
				nxt_ff.idx = cur_ff.idx + 4'h1;
				if (!cur_ff.idx[0]) begin
					nxt_ff.lo = rx_data_in;
				end else if (cur_ff.page <= LAST_PAGE) begin
					mem_we = 1'b1;
					mem_waddr = word_addr(cur_ff.page, cur_ff.idx);
					mem_wdata = {cur_ff.lo, rx_data_in};
				end
				if (cur_ff.idx == 4'hf) begin
					nxt_ff.resp = (cur_ff.page <= LAST_PAGE) ? RSP_ACK
						: RSP_NAK;
					nxt_ff.st = ST_RESP;
				end
			end
		end
		ST_ERASE: begin
			mem_we = 1'b1;
			mem_waddr = cur_ff.erase_ptr[7:0];
			mem_wdata = ERASED_WORD;
			nxt_ff.erase_ptr = cur_ff.erase_ptr + 9'h001;
			if (cur_ff.erase_ptr[7:0] == 8'hff) begin
				nxt_ff.resp = RSP_ACK;
				nxt_ff.st = ST_RESP;
			end
		end
		ST_RD_ACK: begin
			if (tx_ready_in)
				nxt_ff.st = ST_RD_DATA;
		end
		ST_RD_DATA: begin
			if (tx_ready_in) begin
				nxt_ff.sum = cur_ff.sum + rd_byte;
				nxt_ff.idx = cur_ff.idx + 4'h1;
				if (cur_ff.idx == 4'hf)
					nxt_ff.st = ST_RD_SUM;
			end
		end
		ST_RD_SUM: begin
			if (tx_ready_in)
				nxt_ff.st = ST_IDLE;
		end
		ST_CAL_DIV: begin
			if (div_done) begin
				if (div_quot >= GAIN_MIN && div_quot <= GAIN_MAX) begin
					nxt_ff.gain = div_quot[15:0];
					nxt_ff.resp = RSP_ACK;
				end else begin
					nxt_ff.resp = RSP_NAK;
				end
				nxt_ff.st = ST_RESP;
			end
		end
		ST_RESP: begin
			if (tx_ready_in)
				nxt_ff.st = ST_IDLE;
		end
		default: nxt_ff.st = ST_IDLE;
		endcase
	end
	always_ff @(posedge clk_in) begin
		if (sys_rst_in) begin
			cur_ff <= '0;
			cur_ff.ref_f <= FREQ_REF_RST;
			cur_ff.delim <= DELIM_RST;
			cur_ff.gain <= GAIN_FACTORY;
		end else begin
			cur_ff <= nxt_ff;
		end
	end
	// Memory contents survive reset like the real array
	always_ff @(posedge clk_in) begin
		if (mem_we)
			mem_ff[mem_waddr] <= mem_wdata;
	end
	always_comb begin
		tx_valid_out = 1'b0;
		tx_data_out = 8'h00;
		unique case (cur_ff.st)
		ST_RESP: begin
			tx_valid_out = 1'b1;
			tx_data_out = cur_ff.resp;
		end
		ST_RD_ACK: begin
			tx_valid_out = 1'b1;
			tx_data_out = RSP_ACK;
		end
		ST_RD_DATA: begin
			tx_valid_out = 1'b1;
			tx_data_out = rd_byte;
		end
		ST_RD_SUM: begin
			tx_valid_out = 1'b1;
			tx_data_out = cur_ff.sum;
		end
		default: begin
			tx_valid_out = 1'b0;
			tx_data_out = 8'h00;
		end
		endcase
	end
	assign rx_ready_out = (cur_ff.st == ST_IDLE) ||
		(cur_ff.st == ST_PAGE_NUM) || (cur_ff.st == ST_WDATA);
	assign line_freq_out = cur_ff.line_freq;
	assign freq_ok_out = cur_ff.freq_ok;
	assign freq_gain_out = cur_ff.gain;
	sequence s_erase_cmd;
		cur_ff.st == ST_IDLE && rx_valid_in && rx_data_in == CMD_BULK_ERASE;
	endsequence
	a_erase_ack_time: assert property (@(posedge clk_in)
		disable iff (sys_rst_in) s_erase_cmd |-> ##257 (tx_valid_out &&
		tx_data_out == RSP_ACK))
		else $error("bulk erase ack not at expected cycle");
	a_page_bad_nak: assert property (@(posedge clk_in)
		disable iff (sys_rst_in) (cur_ff.st == ST_PAGE_NUM && rx_valid_in
		&& cur_ff.cmd == CMD_PAGE_READ && rx_data_in > LAST_PAGE) |=>
		(tx_valid_out && tx_data_out == RSP_NAK))
		else $error("bad page not refused");
	a_write_guard: assert property (@(posedge clk_in)
		disable iff (sys_rst_in) (cur_ff.st == ST_WDATA &&
		cur_ff.page > LAST_PAGE) |-> !mem_we)
		else $error("write to bad page");
	a_gain_range: assert property (@(posedge clk_in)
		disable iff (sys_rst_in) (cur_ff.st == ST_CAL_DIV && div_done &&
		(div_quot < GAIN_MIN || div_quot > GAIN_MAX)) |=>
		(tx_data_out == RSP_NAK && $stable(freq_gain_out)))
		else $error("out of range gain accepted");
	a_gain_update: assert property (@(posedge clk_in)
		disable iff (sys_rst_in) (cur_ff.st == ST_CAL_DIV && div_done &&
		div_quot >= GAIN_MIN && div_quot <= GAIN_MAX) |=>
		({16'h0000, freq_gain_out} == $past(div_quot)))
		else $error("gain not updated");
	a_freq_band: assert property (@(posedge clk_in)
		disable iff (sys_rst_in) freq_valid_in |=>
		(freq_ok_out == freq_in_band(line_freq_out)))
		else $error("band flag wrong");
	a_freq_hold: assert property (@(posedge clk_in)
		disable iff (sys_rst_in) freq_valid_in |=>
		line_freq_out == $past(freq_meas_in))
		else $error("frequency not captured");
	sequence s_rd_ack_taken;
		cur_ff.st == ST_RD_ACK && tx_ready_in;
	endsequence
	sequence s_rd_byte_taken;
		cur_ff.st == ST_RD_DATA && tx_ready_in;
	endsequence
	a_read_start: assert property (@(posedge clk_in)
		disable iff (sys_rst_in) s_rd_ack_taken |=>
		(cur_ff.st == ST_RD_DATA && cur_ff.idx == 4'h0))
		else $error("page read data not started");
	a_read_len: assert property (@(posedge clk_in)
		disable iff (sys_rst_in) (s_rd_byte_taken ##0
		(cur_ff.idx == 4'hf)) |=> cur_ff.st == ST_RD_SUM)
		else $error("page read length wrong");
	a_write_ack: assert property (@(posedge clk_in)
		disable iff (sys_rst_in) (cur_ff.st == ST_WDATA && rx_valid_in &&
		cur_ff.idx == 4'hf && cur_ff.page <= LAST_PAGE) |=>
		(tx_valid_out && tx_data_out == RSP_ACK))
		else $error("page write not acked");
endmodule : efc_cmd

// file: sim/efc_host_model.sv
// Host model sending command bytes and taking response bytes
`timescale 1ns/100ps
module efc_host_model (
	input wire logic clk_in,
	input wire logic rx_ready_in,
	output logic rx_valid_out,
	output logic [7:0] rx_data_out,
	input wire logic tx_valid_in,
	input wire logic [7:0] tx_data_in,
	output logic tx_ready_out
);
	initial begin
		rx_valid_out = 1'b0;
		rx_data_out = 8'h00;
		tx_ready_out = 1'b0;
	end
	// Enter just after a rising edge; byte held until taken
	task automatic send(input logic [7:0] b, output logic to);
		int i;
		to = 1'b1;
		rx_data_out <= b;
		rx_valid_out <= 1'b1;
		for (i = 0; i < 600; i++) begin
			@(negedge clk_in);
			if (rx_ready_in === 1'b1) begin
				to = 1'b0;
				break;
			end
		end
		@(posedge clk_in);
	endtask : send
	// Idle line shows the inverse of the last byte
	task automatic release_line();
		rx_valid_out <= 1'b0;
		rx_data_out <= ~rx_data_out;
	endtask : release_line
	task automatic recv(input int slow, output logic [7:0] b,
		output logic to);
		int i;
		to = 1'b1;
		b = 8'h00;
		for (i = 0; i < 600; i++) begin
			@(negedge clk_in);
			if (tx_valid_in === 1'b1) begin
				to = 1'b0;
				break;
			end
		end
		repeat (slow) @(negedge clk_in);
		@(posedge clk_in);
		tx_ready_out <= 1'b1;
		@(negedge clk_in);
		b = tx_data_in;
		@(posedge clk_in);
		tx_ready_out <= 1'b0;
	endtask : recv
endmodule : efc_host_model

// file: sim/tb_efc_cmd.sv
// Self-checking bench for the calibration and memory command block
`timescale 1ns/100ps
module tb_efc_cmd;
	import efc_pkg::*;
	logic clk_in, sys_rst_in, rx_valid, rx_ready, tx_valid, tx_ready;
	logic [7:0] rx_data, tx_data;
	logic freq_valid, ref_load, delim_load, freq_ok;
	logic [15:0] freq_meas, freq_ref, delim, line_freq, gain;
	logic [15:0] mem [256];
	int error_cnt, n_compared;
	efc_cmd dut_u (.clk_in(clk_in), .sys_rst_in(sys_rst_in),
		.rx_valid_in(rx_valid), .rx_data_in(rx_data),
		.rx_ready_out(rx_ready), .tx_valid_out(tx_valid),
		.tx_data_out(tx_data), .tx_ready_in(tx_ready),
		.freq_valid_in(freq_valid), .freq_meas_in(freq_meas),
		.freq_ref_in(freq_ref), .ref_load_in(ref_load),
		.delim_in(delim), .delim_load_in(delim_load),
		.line_freq_out(line_freq), .freq_ok_out(freq_ok),
		.freq_gain_out(gain));
	efc_host_model host_u (.clk_in(clk_in), .rx_ready_in(rx_ready),
		.rx_valid_out(rx_valid), .rx_data_out(rx_data),
		.tx_valid_in(tx_valid), .tx_data_in(tx_data),
		.tx_ready_out(tx_ready));
	initial begin
		clk_in = 1'b0;
		forever #4 clk_in = ~clk_in;
	end
	task automatic final_report();
		if (error_cnt == 0 && n_compared > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask : final_report
	task automatic chk(input logic [15:0] s, input logic [15:0] e);
		n_compared++;
		if (s !== e) begin
			error_cnt++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask : chk
	task automatic put(input logic [7:0] b);
		logic to;
		host_u.send(b, to);
		if (to === 1'b1) begin
			error_cnt++;
			final_report();
		end
	endtask : put
	task automatic get(input logic [7:0] e);
		logic to;
		logic [7:0] b;
		host_u.recv(n_compared % 3, b, to);
		if (to === 1'b1) begin
			error_cnt++;
			final_report();
		end
		chk({8'h00, b}, {8'h00, e});
	endtask : get
	task automatic cmd(input logic [7:0] c, input logic [7:0] e);
		put(c);
		host_u.release_line();
		get(e);
	endtask : cmd
	task automatic do_reset();
		sys_rst_in <= 1'b1;
		repeat (12) @(posedge clk_in);
		sys_rst_in <= 1'b0;
		repeat (3) @(posedge clk_in);
	endtask : do_reset
	task automatic set_freq(input logic [15:0] v);
		freq_meas <= v;
		freq_valid <= 1'b1;
		@(posedge clk_in);
		freq_valid <= 1'b0;
		@(posedge clk_in);
	endtask : set_freq
	task automatic load_ref(input logic [15:0] v);
		freq_ref <= v;
		ref_load <= 1'b1;
		@(posedge clk_in);
		ref_load <= 1'b0;
		@(posedge clk_in);
	endtask : load_ref
	task automatic erase();
		cmd(CMD_BULK_ERASE, RSP_ACK);
		for (int i = 0; i < 256; i++) mem[i] = ERASED_WORD;
	endtask : erase
	task automatic rd_page(input logic [7:0] p);
		logic [15:0] wd;
		logic [7:0] s;
		put(CMD_PAGE_READ);
		put(p);
		host_u.release_line();
		if (p > LAST_PAGE) begin
			get(RSP_NAK);
			return;
		end
		get(RSP_ACK);
		s = 8'h00;
		for (int w = 0; w < 8; w++) begin
			wd = mem[p * 8 + w];
			get(wd[15:8]);
			get(wd[7:0]);
			s = s + wd[15:8] + wd[7:0];
		end
		get(s);
	endtask : rd_page
	task automatic wr_page(input logic [7:0] p, input logic [7:0] sd);
		logic [15:0] wd;
		put(CMD_PAGE_WRITE);
		put(p);
		for (int w = 0; w < 8; w++) begin
			wd = {sd + 8'(w), 8'(w * 17) ^ sd};
			put(wd[15:8]);
			put(wd[7:0]);
			if (p <= LAST_PAGE) mem[p * 8 + w] = wd;
		end
		host_u.release_line();
		get((p > LAST_PAGE) ? RSP_NAK : RSP_ACK);
	endtask : wr_page
	task automatic t_band();
		logic [15:0] fv [4] = '{16'hafc7, 16'hafc8, 16'hfde8, 16'hfde9};
		for (int i = 0; i < 4; i++) begin
			set_freq(fv[i]);
			chk(line_freq, fv[i]);
			chk({15'h0, freq_ok}, {15'h0, i == 1 || i == 2});
		end
	endtask : t_band
	task automatic t_memory();
		erase();
		rd_page(8'h00);
		rd_page(8'h1f);
		wr_page(8'h1f, 8'h5a);
		wr_page(8'h00, 8'ha3);
		rd_page(8'h1f);
		wr_page(8'h20, 8'h77);
		wr_page(8'hff, 8'h3c);
		rd_page(8'h20);
		rd_page(8'h00);
		rd_page(8'h1f);
		erase();
		rd_page(8'h1f);
	endtask : t_memory
	task automatic t_cal();
		set_freq(16'hfde9);
		cmd(CMD_AUTO_FREQ, RSP_NAK);
		chk(gain, GAIN_FACTORY);
		set_freq(16'hfa00);
		load_ref(FREQ_REF_RST);
		cmd(CMD_AUTO_FREQ, RSP_ACK);
		chk(gain, 16'h6400);
		chk(line_freq, 16'hfa00);
		load_ref(16'hafc8);
		set_freq(16'hfde8);
		cmd(CMD_AUTO_FREQ, RSP_NAK);
		chk(gain, 16'h6400);
		cmd(CMD_SAVE_NV, RSP_ACK);
		do_reset();
		chk(gain, 16'h6400);
		delim <= DELIM_KEY;
		delim_load <= 1'b1;
		@(posedge clk_in);
		delim_load <= 1'b0;
		@(posedge clk_in);
		cmd(CMD_SAVE_NV, RSP_ACK);
		do_reset();
		chk(gain, GAIN_FACTORY);
		do_reset();
		chk(gain, GAIN_FACTORY);
	endtask : t_cal
	initial begin
		error_cnt = 0;
		n_compared = 0;
		sys_rst_in = 1'b1;
		freq_valid = 1'b0;
		freq_meas = 16'h0000;
		freq_ref = 16'h0000;
		ref_load = 1'b0;
		delim = 16'h0000;
		delim_load = 1'b0;
		repeat (12) @(posedge clk_in);
		sys_rst_in <= 1'b0;
		repeat (3) @(posedge clk_in);
		chk(gain, GAIN_FACTORY);
		chk({15'h0, freq_ok}, 16'h0000);
		t_band();
		t_memory();
		t_cal();
		final_report();
	end
endmodule : tb_efc_cmd
